// [smc_sleep_ctrl.sv]
// module: sleep mode controller with its misc setup register
`timescale 1ns/10ps
`default_nettype none
module smc_sleep_ctrl
  import smc_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // host i/o port
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic [7:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  output logic io_rvalid_o,
  // sleep pin and interrupt inputs
  input wire logic sleep_req_n_i,
  input wire logic [SMC_IRQ_W-1:0] irq_i,
  // keyboard reset command and cache decode from the rest of the chip
  input wire logic kbd_reset_cmd_i,
  input wire logic cache_decode_hit_i,
  // sleep effects
  output logic asleep_o,
  output logic bus_hold_req_o,
  output logic refresh_div_en_o,
  output logic bus_oscillator_gate_en_o,
  output logic sys_clock_en_o,
  output logic essential_clk_en_o,
  // setup effects
  output logic cpu_reset_request_n_o,
  output logic cache_enable_n_o,
  output logic parity_check_en_o,
  output logic cas_wait_en_o,
  output logic [SMC_IRQ_W-1:0] irq_o
);
  smc_io_req_t req;
  smc_cfg_t cfg;
  smc_state_t state;
  smc_state_t next_state;
  logic pin_s1;
  logic pin_s2;
  logic pin_last;
  logic [7:0] index;
  logic [7:0] misc_wr;
  logic [15:0] rc_cnt;
  logic [15:0] next_rc_cnt;
  logic rc_wait;
  logic rc_pulse;
  logic [SMC_IRQ_W-1:0] irq_f;

  assign req = '{rd: io_rd_i, wr: io_wr_i, addr: io_addr_i, wdata: io_wdata_i};

  // decode
  wire sel_index = req.addr == SMC_PORT_INDEX;
  wire sel_data = req.addr == SMC_PORT_DATA;
  wire sel_misc = sel_data && index == SMC_MISC_SETUP_IDX;
  wire misc_we = req.wr && sel_misc;
  wire pin_fall = pin_last && !pin_s2;
  wire pin_rise = !pin_last && pin_s2;
  wire any_irq = |irq_f;
  wire sleep_bit = misc_wr[SMC_BIT_SLEEP];
  wire sleep_set = misc_we && req.wdata[SMC_BIT_SLEEP];
  wire sleep_clr_wr = misc_we && !req.wdata[SMC_BIT_SLEEP];
  wire [7:0] misc_view = {misc_wr[7], pin_s2, misc_wr[5:0]};
  wire [7:0] next_rdata = sel_index ? index : (sel_misc ? misc_view : 8'h00);
  wire [15:0] rc_delay = cfg.quick_cpu_reset ? 16'(SMC_RC_QUICK_CYC)
                                             : 16'(SMC_RC_DELAY_CYC);

  assign cfg = '{quick_cpu_reset: misc_wr[SMC_BIT_QRST],
                 cache_allow: misc_wr[SMC_BIT_CACHE],
                 parity_disable: misc_wr[SMC_BIT_PARD],
                 cas_extra_wait_off: misc_wr[SMC_BIT_CASW],
                 irq_deglitch: misc_wr[SMC_BIT_DEGL]};

  // sleep pin synchroniser; only the second stage and its delayed copy pin_last are looked at
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      pin_last <= 1'b1;
    end else if (ce_i) begin
      pin_s1 <= sleep_req_n_i;
      pin_s2 <= pin_s1;
      pin_last <= pin_s2;
    end
  end

  // index port and setup register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      index <= 8'h00;
      misc_wr <= SMC_MISC_RESET;
    end else if (ce_i) begin
      if (req.wr && sel_index) begin
        index <= req.wdata;
      end
      if (misc_we) begin
        misc_wr <= req.wdata & SMC_MISC_WMASK;
      end else if (state == SMC_ASLEEP && any_irq) begin
        // wake by interrupt drops the command so software must set it again
        misc_wr[SMC_BIT_SLEEP] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      io_rdata_o <= 8'h00;
      io_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      io_rdata_o <= req.rd ? next_rdata : io_rdata_o;
      io_rvalid_o <= req.rd && (sel_index || sel_data);
    end
  end

  // sleep state; a same-cycle software set beats an interrupt wake
  always_comb begin
    next_state = state;
    case (state)
      SMC_AWAKE: begin
        if (sleep_set || pin_fall) begin
          next_state = SMC_ASLEEP;
        end
      end
      SMC_ASLEEP: begin
        if (sleep_clr_wr || pin_rise || (any_irq && !sleep_set)) begin
          next_state = SMC_AWAKE;
        end
      end
      default: next_state = SMC_AWAKE;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= SMC_AWAKE;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // cpu reset delay and pulse counter
  always_comb begin
    next_rc_cnt = rc_cnt;
    if (kbd_reset_cmd_i && !rc_wait && !rc_pulse) begin
      next_rc_cnt = rc_delay;
    end else if (rc_cnt != 16'h0000) begin
      next_rc_cnt = rc_cnt - 16'h0001;
    end else if (rc_wait) begin
      // zero counts as a pulse cycle, so load one less
      next_rc_cnt = 16'(SMC_RC_PULSE_CYC - 1);
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rc_cnt <= 16'h0000;
      rc_wait <= 1'b0;
      rc_pulse <= 1'b0;
    end else if (ce_i) begin
      rc_cnt <= next_rc_cnt;
      if (kbd_reset_cmd_i && !rc_wait && !rc_pulse) begin
        rc_wait <= 1'b1;
      end else if (rc_wait && rc_cnt == 16'h0000) begin
        rc_wait <= 1'b0;
        rc_pulse <= 1'b1;
      end else if (rc_pulse && rc_cnt == 16'h0000) begin
        rc_pulse <= 1'b0;
      end
    end
  end

  // registered outputs
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      asleep_o <= 1'b0;
      bus_hold_req_o <= 1'b0;
      refresh_div_en_o <= 1'b0;
      bus_oscillator_gate_en_o <= 1'b1;
      sys_clock_en_o <= 1'b1;
      essential_clk_en_o <= 1'b1;
      cpu_reset_request_n_o <= 1'b1;
      cache_enable_n_o <= 1'b1;
      parity_check_en_o <= 1'b1;
      cas_wait_en_o <= 1'b1;
    end else if (ce_i) begin
      asleep_o <= next_state == SMC_ASLEEP;
      bus_hold_req_o <= next_state == SMC_ASLEEP;
      refresh_div_en_o <= next_state == SMC_ASLEEP;
      bus_oscillator_gate_en_o <= next_state != SMC_ASLEEP;
      // gating follows the command bit unless keep-on is set; every setup write reloads keep-on
      sys_clock_en_o <= misc_wr[SMC_BIT_KEEP] || !sleep_bit;
      essential_clk_en_o <= 1'b1;
      cpu_reset_request_n_o <= !rc_pulse;
      cache_enable_n_o <= !(cfg.cache_allow && cache_decode_hit_i);
      parity_check_en_o <= !cfg.parity_disable;
      cas_wait_en_o <= !cfg.cas_extra_wait_off;
    end
  end

  genvar g;
  generate
    for (g = 0; g < SMC_IRQ_W; g++) begin : g_irq
      smc_irq_filter smc_irq_filter_inst (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .enable_i(cfg.irq_deglitch),
        .irq_i(irq_i[g]),
        .irq_o(irq_f[g])
      );
    end
  endgenerate

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_o <= '0;
    end else if (ce_i) begin
      irq_o <= irq_f;
    end
  end

  // assertions
  sequence s_fall_seen;
    ce_i && state == SMC_AWAKE && pin_fall;
  endsequence

  sequence s_irq_wake;
    ce_i && state == SMC_ASLEEP && any_irq && !sleep_set;
  endsequence

  a_pin_enters_sleep: assert property (@(posedge clk_i) disable iff (reset_i)
      s_fall_seen |=> asleep_o && bus_hold_req_o)
    else $error("pin fall did not enter sleep");
  a_sw_enters_sleep: assert property (@(posedge clk_i) disable iff (reset_i)
      (ce_i && sleep_set) |=> asleep_o && misc_wr[SMC_BIT_SLEEP])
    else $error("sleep command did not enter sleep");
  a_sleep_effects: assert property (@(posedge clk_i) disable iff (reset_i)
      asleep_o |-> bus_hold_req_o && refresh_div_en_o && !bus_oscillator_gate_en_o)
    else $error("sleep effects missing");
  a_essential_clocks: assert property (@(posedge clk_i) disable iff (reset_i)
      asleep_o |-> essential_clk_en_o)
    else $error("essential clocks stopped");
  a_sw_clear_wakes: assert property (@(posedge clk_i) disable iff (reset_i)
      (ce_i && state == SMC_ASLEEP && sleep_clr_wr) |=> !asleep_o)
    else $error("clearing sleep command did not wake");
  a_pin_rise_wakes: assert property (@(posedge clk_i) disable iff (reset_i)
      (ce_i && state == SMC_ASLEEP && pin_rise) |=> !asleep_o)
    else $error("pin rise did not wake");
  a_irq_wakes: assert property (@(posedge clk_i) disable iff (reset_i)
      s_irq_wake |=> !asleep_o ##0 !misc_wr[SMC_BIT_SLEEP])
    else $error("interrupt did not wake");
  a_pin_level_read: assert property (@(posedge clk_i) disable iff (reset_i)
      (ce_i && req.rd && sel_misc) |=> io_rdata_o[SMC_BIT_PIN] == $past(pin_s2))
    else $error("pin level bit wrong");
  a_system_clock_stop: assert property (@(posedge clk_i) disable iff (reset_i)
      (ce_i && !misc_wr[SMC_BIT_KEEP] && sleep_bit) |=> !sys_clock_en_o)
    else $error("system clock not stopped");
  a_quick_reset_delay: assert property (@(posedge clk_i) disable iff (reset_i)
      (ce_i && kbd_reset_cmd_i && !rc_wait && !rc_pulse && cfg.quick_cpu_reset)
      |=> rc_cnt == 16'(SMC_RC_QUICK_CYC))
    else $error("quick reset delay wrong");
  a_cache_forced_off: assert property (@(posedge clk_i) disable iff (reset_i)
      (ce_i && !cfg.cache_allow) |=> cache_enable_n_o)
    else $error("cache enable not held high");
  a_parity_off: assert property (@(posedge clk_i) disable iff (reset_i)
      (ce_i && cfg.parity_disable) |=> !parity_check_en_o)
    else $error("parity still checked");
  a_cas_wait_off: assert property (@(posedge clk_i) disable iff (reset_i)
      (ce_i && cfg.cas_extra_wait_off) |=> !cas_wait_en_o)
    else $error("cas waits still inserted");
  a_index_write: assert property (@(posedge clk_i) disable iff (reset_i)
      (ce_i && req.wr && sel_index) |=> index == $past(req.wdata))
    else $error("index not stored");
  a_wake_restores: assert property (@(posedge clk_i) disable iff (reset_i)
      (ce_i && state == SMC_ASLEEP && next_state == SMC_AWAKE)
      |=> bus_oscillator_gate_en_o && !bus_hold_req_o && !refresh_div_en_o)
    else $error("wake did not restore clocks");
  a_pin_sync_chain: assert property (@(posedge clk_i) disable iff (reset_i)
      ce_i |=> pin_s2 == $past(pin_s1))
    else $error("pin synchroniser skipped a stage");
endmodule : smc_sleep_ctrl
`default_nettype wire

// [smc_pkg.sv]
// package: constants and carrier types for the sleep mode controller
`default_nettype none
package smc_pkg;
  // i/o port addresses of the indexed configuration space
  localparam logic [7:0] SMC_PORT_INDEX = 8'hec;
  localparam logic [7:0] SMC_PORT_DATA = 8'hed;
  localparam logic [7:0] SMC_MISC_SETUP_IDX = 8'h07;
  // misc_setup field positions
  localparam int SMC_BIT_SLEEP = 7;
  localparam int SMC_BIT_PIN = 6;
  localparam int SMC_BIT_KEEP = 5;
  localparam int SMC_BIT_QRST = 4;
  localparam int SMC_BIT_CACHE = 3;
  localparam int SMC_BIT_PARD = 2;
  localparam int SMC_BIT_CASW = 1;
  localparam int SMC_BIT_DEGL = 0;
  // writable bits reset value (bit 6 is the live pin level)
  localparam logic [7:0] SMC_MISC_RESET = 8'h21;
  localparam logic [7:0] SMC_MISC_WMASK = 8'hbf;
  // timing
  localparam int SMC_CLK_MHZ = 100;
  localparam int SMC_RC_DELAY_NS = 50000;
  localparam int SMC_RC_QUICK_NS = 6720;
  localparam int SMC_DEGLITCH_NS = 105;
  localparam int SMC_RC_DELAY_CYC = SMC_RC_DELAY_NS * SMC_CLK_MHZ / 1000;
  localparam int SMC_RC_QUICK_CYC = SMC_RC_QUICK_NS * SMC_CLK_MHZ / 1000;
  localparam int SMC_DEGLITCH_CYC = (SMC_DEGLITCH_NS * SMC_CLK_MHZ + 999) / 1000;
  localparam int SMC_RC_PULSE_CYC = 600;
  localparam int SMC_IRQ_W = 16;

  // i/o access from the host side
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } smc_io_req_t;

  // setup bits handed to the rest of the controller
  typedef struct packed {
    logic quick_cpu_reset;
    logic cache_allow;
    logic parity_disable;
    logic cas_extra_wait_off;
    logic irq_deglitch;
  } smc_cfg_t;

  typedef enum logic [1:0] {
    SMC_AWAKE,
    SMC_ASLEEP
  } smc_state_t;
endpackage : smc_pkg
`default_nettype wire

// [smc_irq_filter.sv]
// module: one interrupt line with optional stability filter
`timescale 1ns/10ps
`default_nettype none
module smc_irq_filter
  import smc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // line
  input wire logic enable_i,
  input wire logic irq_i,
  output logic irq_o
);
  logic sync1;
  logic sync2;
  logic [7:0] stable_cnt;
  logic last;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      last <= 1'b0;
      stable_cnt <= 8'h00;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      sync1 <= irq_i;
      sync2 <= sync1;
      last <= sync2;
      if (sync2 != last) begin
        stable_cnt <= 8'h00;
      end else if (stable_cnt < 8'(SMC_DEGLITCH_CYC)) begin
        stable_cnt <= stable_cnt + 8'h01;
      end
      // level must hold its value for the full window before it passes
      if (!enable_i) begin
        irq_o <= sync2;
      end else if (sync2 == last && stable_cnt >= 8'(SMC_DEGLITCH_CYC - 1)) begin
        irq_o <= sync2;
      end
    end
  end

  a_filter_holds: assert property (@(posedge clk_i) disable iff (reset_i)
      (enable_i && ce_i && $rose(irq_o)) |-> $past(sync2, 2))
    else $error("filtered irq rose on unstable input");
endmodule : smc_irq_filter
`default_nettype wire

// [smc_host_model.sv]
// host cpu and bios model: drives the index and data i/o ports
`timescale 1ns/10ps
`default_nettype none
module smc_host_model
  import smc_pkg::*;
(
  // clock
  input wire logic clk_i,
  // i/o strobes toward the controller
  output logic io_rd_o,
  output logic io_wr_o,
  output logic [7:0] io_addr_o,
  output logic [7:0] io_wdata_o,
  // read answer
  input wire logic [7:0] io_rdata_i,
  input wire logic io_rvalid_i
);
  initial begin
    io_rd_o = 1'b0;
    io_wr_o = 1'b0;
    io_addr_o = 8'h00;
    io_wdata_o = 8'h00;
  end

  // one access; address and data are inverted once released so stale values never match
  task automatic io_cycle(input logic rd, input logic [7:0] addr, input logic [7:0] data,
                          output logic [7:0] rdata, output logic rvalid);
    @(posedge clk_i);
    #1;
    io_rd_o = rd;
    io_wr_o = !rd;
    io_addr_o = addr;
    io_wdata_o = data;
    @(posedge clk_i);
    #1;
    io_rd_o = 1'b0;
    io_wr_o = 1'b0;
    io_addr_o = ~addr;
    io_wdata_o = ~data;
    rdata = io_rdata_i;
    rvalid = io_rvalid_i;
  endtask : io_cycle

  // index first, then data port
  task automatic setup_write(input logic [7:0] data);
    logic [7:0] d;
    logic v;
    io_cycle(1'b0, SMC_PORT_INDEX, SMC_MISC_SETUP_IDX, d, v);
    io_cycle(1'b0, SMC_PORT_DATA, data, d, v);
  endtask : setup_write

  task automatic setup_read(output logic [7:0] data, output logic valid);
    logic [7:0] d;
    logic v;
    io_cycle(1'b0, SMC_PORT_INDEX, SMC_MISC_SETUP_IDX, d, v);
    io_cycle(1'b1, SMC_PORT_DATA, 8'h00, data, valid);
  endtask : setup_read

  // keep-on is programmed here; every later setup write rewrites all writable bits, keep-on included
  task automatic firmware_init();
    setup_write(SMC_MISC_RESET);
  endtask : firmware_init
endmodule : smc_host_model
`default_nettype wire

// [smc_sleep_ctrl_tb.sv]
// self-checking testbench for the sleep mode controller
`timescale 1ns/10ps
`default_nettype none
module smc_sleep_ctrl_tb;
  import smc_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i, ce_i, sleep_req_n_i, kbd_reset_cmd_i, cache_decode_hit_i;
  logic io_rd, io_wr, io_rvalid_o, asleep_o, bus_hold_req_o, refresh_div_en_o;
  logic bus_oscillator_gate_en_o, sys_clock_en_o, essential_clk_en_o;
  logic cpu_reset_request_n_o, cache_enable_n_o, parity_check_en_o, cas_wait_en_o;
  logic [7:0] io_addr, io_wdata, io_rdata_o, rd_data;
  logic [SMC_IRQ_W-1:0] irq_i, irq_o;
  logic rd_valid;
  int fail_count = 0;
  int n_checks = 0;
  wire [7:0] sleep_vec = {2'b00, asleep_o, bus_hold_req_o, refresh_div_en_o,
                          bus_oscillator_gate_en_o, sys_clock_en_o, essential_clk_en_o};
  wire [7:0] cfg_vec = {4'h0, cpu_reset_request_n_o, cache_enable_n_o,
                        parity_check_en_o, cas_wait_en_o};

  always #5 clk_i = ~clk_i;

  smc_sleep_ctrl smc_sleep_ctrl_inst (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
    .io_rd_i(io_rd), .io_wr_i(io_wr), .io_addr_i(io_addr), .io_wdata_i(io_wdata),
    .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o), .sleep_req_n_i(sleep_req_n_i),
    .irq_i(irq_i), .kbd_reset_cmd_i(kbd_reset_cmd_i), .cache_decode_hit_i(cache_decode_hit_i),
    .asleep_o(asleep_o), .bus_hold_req_o(bus_hold_req_o), .refresh_div_en_o(refresh_div_en_o),
    .bus_oscillator_gate_en_o(bus_oscillator_gate_en_o), .sys_clock_en_o(sys_clock_en_o),
    .essential_clk_en_o(essential_clk_en_o), .cpu_reset_request_n_o(cpu_reset_request_n_o),
    .cache_enable_n_o(cache_enable_n_o), .parity_check_en_o(parity_check_en_o),
    .cas_wait_en_o(cas_wait_en_o), .irq_o(irq_o));

  smc_host_model smc_host_model_inst (.clk_i(clk_i), .io_rd_o(io_rd), .io_wr_o(io_wr),
    .io_addr_o(io_addr), .io_wdata_o(io_wdata), .io_rdata_i(io_rdata_o),
    .io_rvalid_i(io_rvalid_o));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk8

  // counts allow a few cycles for synchroniser and register stages
  task automatic chk_cnt(input string name, input int exp, input int got);
    n_checks++;
    if (got < exp - 3 || got > exp + 3) begin
      fail_count++;
      $display("wrong value %s expected %0d seen %0d", name, exp, got);
    end
  endtask : chk_cnt

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic wr_misc(input logic [7:0] d);
    smc_host_model_inst.setup_write(d);
    tick(2);
  endtask : wr_misc

  task automatic rd_misc(input logic [7:0] mask, input logic [7:0] exp);
    smc_host_model_inst.setup_read(rd_data, rd_valid);
    chk8("misc_setup", exp, rd_data & mask);
    chk8("read valid", 8'h01, {7'h00, rd_valid});
  endtask : rd_misc

  task automatic irq_pulse(input int n);
    irq_i[3] = 1'b1;
    tick(n);
    irq_i[3] = 1'b0;
  endtask : irq_pulse

  task automatic rc_measure(input int exp);
    int n;
    kbd_reset_cmd_i = 1'b1;
    tick(1);
    kbd_reset_cmd_i = 1'b0;
    n = 0;
    while (cpu_reset_request_n_o !== 1'b0 && n < 8000) begin
      tick(1);
      n++;
    end
    chk_cnt("reset delay", exp, n);
    n = 0;
    while (cpu_reset_request_n_o === 1'b0 && n < 2000) begin
      tick(1);
      n++;
    end
    chk_cnt("reset pulse", SMC_RC_PULSE_CYC, n);
  endtask : rc_measure

  initial begin
    #400000;
    fail_count++;
    complete_run();
  end

  initial begin
    reset_i = 1'b1;
    ce_i = 1'b1;
    sleep_req_n_i = 1'b1;
    irq_i = '0;
    kbd_reset_cmd_i = 1'b0;
    cache_decode_hit_i = 1'b1;
    tick(16);
    reset_i = 1'b0;
    chk8("sleep outputs", 8'h07, sleep_vec);
    chk8("setup outputs", 8'h0f, cfg_vec);
    rd_misc(8'hff, 8'h61);
    smc_host_model_inst.firmware_init();
    // bit 6 written low must still read the pin level
    wr_misc(8'h0e);
    chk8("setup outputs", 8'h08, cfg_vec);
    cache_decode_hit_i = 1'b0;
    tick(2);
    chk8("setup outputs", 8'h0c, cfg_vec);
    rd_misc(8'hff, 8'h4e);
    wr_misc(8'h80);
    chk8("sleep outputs", 8'h39, sleep_vec);
    rd_misc(8'hff, 8'hc0);
    wr_misc(8'h00);
    chk8("sleep outputs", 8'h07, sleep_vec);
    wr_misc(8'ha0);
    chk8("sleep outputs", 8'h3b, sleep_vec);
    wr_misc(8'h21);
    chk8("sleep outputs", 8'h07, sleep_vec);
    sleep_req_n_i = 1'b0;
    tick(8);
    chk8("sleep outputs", 8'h3b, sleep_vec);
    rd_misc(8'h7f, 8'h21);
    sleep_req_n_i = 1'b1;
    tick(8);
    chk8("sleep outputs", 8'h07, sleep_vec);
    // deglitch on: a short request must not wake, a held one must
    sleep_req_n_i = 1'b0;
    tick(8);
    irq_pulse(5);
    tick(20);
    chk8("sleep outputs", 8'h3b, sleep_vec);
    irq_i[3] = 1'b1;
    tick(30);
    chk8("irq out", 8'h08, irq_o[7:0]);
    chk8("sleep outputs", 8'h07, sleep_vec);
    irq_i[3] = 1'b0;
    // the filtered line needs its full window before it falls
    tick(16);
    rd_misc(8'hc0, 8'h00);
    wr_misc(8'ha1);
    chk8("sleep outputs", 8'h3b, sleep_vec);
    wr_misc(8'h21);
    chk8("sleep outputs", 8'h07, sleep_vec);
    // deglitch off: a short request passes
    wr_misc(8'ha0);
    chk8("sleep outputs", 8'h3b, sleep_vec);
    irq_pulse(4);
    tick(10);
    chk8("sleep outputs", 8'h07, sleep_vec);
    rd_misc(8'h80, 8'h00);
    sleep_req_n_i = 1'b1;
    tick(8);
    wr_misc(8'ha0);
    chk8("sleep outputs", 8'h3b, sleep_vec);
    reset_i = 1'b1;
    tick(1);
    chk8("sleep outputs", 8'h07, sleep_vec);
    reset_i = 1'b0;
    rd_misc(8'hff, 8'h61);
    rc_measure(SMC_RC_DELAY_NS / 10);
    wr_misc(8'h31);
    rc_measure(SMC_RC_QUICK_NS / 10);
    smc_host_model_inst.io_cycle(1'b1, 8'hec, 8'h00, rd_data, rd_valid);
    chk8("index read", 8'h07, rd_data);
    smc_host_model_inst.io_cycle(1'b0, 8'hec, 8'h05, rd_data, rd_valid);
    smc_host_model_inst.io_cycle(1'b1, 8'hed, 8'h00, rd_data, rd_valid);
    chk8("unmapped index", 8'h00, rd_data);
    smc_host_model_inst.io_cycle(1'b1, 8'h70, 8'h00, rd_data, rd_valid);
    chk8("foreign port valid", 8'h00, {7'h00, rd_valid});
    // a frozen clock enable must swallow the whole write
    ce_i = 1'b0;
    wr_misc(8'h80);
    chk8("sleep outputs", 8'h07, sleep_vec);
    ce_i = 1'b1;
    rd_misc(8'h80, 8'h00);
    complete_run();
  end
endmodule : smc_sleep_ctrl_tb
`default_nettype wire
